//--- design/flash_guard_pkg.sv
// Constants, enumerations and helpers for the serial flash framing and
// protection logic. Assumes the including design runs on a single clk.
package flash_guard_pkg;
   localparam int ADDR_W        = 22;
   localparam int BLOCK_CNT     = 64;
   localparam int BLK_LSB       = 16;
   localparam int SEC_LSB       = 12;
   localparam int SEC_IN_BLK    = 16;
   localparam int OTP_ROW_SEL   = 9;
   localparam int OTP_ADDR_W    = 10;
   localparam logic [3:0] CODE_NONE    = 4'h0;
   localparam logic [3:0] CODE_MAX_PART = 4'h6;
   localparam logic [5:0] BLK_TOP      = 6'h3F;
   localparam logic [5:0] BLK_BOT      = 6'h00;
   localparam logic [7:0] CMD_LATCH_SET = 8'h06;
   localparam logic [7:0] CMD_WRDI  = 8'h04;
   localparam logic [7:0] CMD_READ  = 8'h03;
   localparam logic [7:0] CMD_FREAD = 8'h0B;
   localparam logic [7:0] CMD_RDSR  = 8'h05;
   localparam logic [7:0] CMD_RDID  = 8'h9F;
   localparam logic [7:0] CMD_PP    = 8'h02;
   localparam logic [7:0] CMD_SE    = 8'h20;
   localparam logic [7:0] CMD_BE32  = 8'h52;
   localparam logic [7:0] CMD_BE    = 8'hD8;
   localparam logic [7:0] CMD_CE1   = 8'h60;
   localparam logic [7:0] CMD_CE2   = 8'hC7;
   localparam logic [7:0] CMD_STATUS_WRITE = 8'h01;
   localparam logic [7:0] CMD_OTP_ENTER  = 8'hB1;
   localparam logic [7:0] CMD_OTP_EXIT   = 8'hC1;
   localparam logic [7:0] CMD_SEC_WRITE  = 8'h2F;
   localparam logic [7:0] CMD_QUAD_ENTER = 8'h35;
   localparam logic [7:0] CMD_QUAD_LEAVE = 8'hF5;
   localparam logic [7:0] CMD_NOP   = 8'h00;

   typedef enum logic [2:0] {
      OP_NONE, OP_PROG, OP_ERASE, OP_CHIP, OP_STATUS
   } op_type;

   // Protect decode: true when a block index falls in the protected range.
   function automatic logic block_guarded(input logic [3:0] code,
                                          input logic       bottom,
                                          input logic [5:0] blk);
      logic [6:0] span;
      span = 7'h00;
      if (code == CODE_NONE) begin
         return 1'b0;
      end
      if (code > CODE_MAX_PART) begin
         return 1'b1;
      end
      span = 7'(7'h01 << (code - 4'h1));
      if (bottom) begin
         return {1'b0, blk} < span;
      end
      return {1'b0, blk} >= 7'(7'h40 - span);
   endfunction
endpackage

//--- design/flash_lock_map.sv
// Lock granularity map: one lock bit per 4K sector in the two end blocks
// and one per 64K block elsewhere. Assumes a single clk domain.
`timescale 1ns/1ns
module flash_lock_map
   import flash_guard_pkg::*;
#(
   parameter int AW = flash_guard_pkg::ADDR_W
) (
   input  wire logic          clk,
   input  wire logic          rst,
   input  wire logic          lock_we,
   input  wire logic          lock_val,
   input  wire logic          lock_all,
   input  wire logic [AW-1:0] lock_addr,
   input  wire logic [AW-1:0] chk_addr,
   output logic               chk_locked
);
   logic [BLOCK_CNT-1:0]  blk_lock_r;
   logic [SEC_IN_BLK-1:0] bot_lock_r;
   logic [SEC_IN_BLK-1:0] top_lock_r;
   wire logic [5:0] wr_blk = lock_addr[AW-1:BLK_LSB];
   wire logic [3:0] wr_sec = lock_addr[BLK_LSB-1:SEC_LSB];
   wire logic [5:0] rd_blk = chk_addr[AW-1:BLK_LSB];
   wire logic [3:0] rd_sec = chk_addr[BLK_LSB-1:SEC_LSB];

   // End blocks resolve per sector, the rest per block.
   assign chk_locked = (rd_blk == BLK_BOT) ? bot_lock_r[rd_sec] :
                       (rd_blk == BLK_TOP) ? top_lock_r[rd_sec] :
                       blk_lock_r[rd_blk];

   // Gang commands set or clear every unit at once.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         blk_lock_r <= '0;
         bot_lock_r <= '0;
         top_lock_r <= '0;
      end else if (lock_all) begin
         blk_lock_r <= {BLOCK_CNT{lock_val}};
         bot_lock_r <= {SEC_IN_BLK{lock_val}};
         top_lock_r <= {SEC_IN_BLK{lock_val}};
      end else if (lock_we) begin
         if (wr_blk == BLK_BOT) begin
            bot_lock_r[wr_sec] <= lock_val;
         end else if (wr_blk == BLK_TOP) begin
            top_lock_r[wr_sec] <= lock_val;
         end else begin
            blk_lock_r[wr_blk] <= lock_val;
         end
      end
   end
endmodule

//--- design/flash_guard.sv
// Command framing and protection core of a serial NOR flash. Samples the
// host's serial clock and select on clk, frames commands, and issues
// program/erase/OTP strobes to an array engine. Assumes the serial clock
// is at most an eighth of clk and that the engine reports busy.
`timescale 1ns/1ns
module flash_guard
   import flash_guard_pkg::*;
#(
   parameter int AW = flash_guard_pkg::ADDR_W
) (
   input  wire logic                  clk,
   input  wire logic                  rst,
   input  wire logic                  sclk,
   input  wire logic                  cs_n,
   input  wire logic [3:0]            sio_in,
   output logic [3:0]                 sio_out,
   output logic [3:0]                 sio_oe,
   input  wire logic                  wp_n,
   input  wire logic [3:0]            protect_code,
   input  wire logic                  protect_bottom,
   input  wire logic                  quad_lines_enable,
   input  wire logic                  factory_lock,
   input  wire logic                  engine_busy,
   input  wire logic [7:0]            status_byte,
   output logic                       op_start,
   output flash_guard_pkg::op_type    op_kind,
   output logic [AW-1:0]              op_addr,
   output logic                       op_otp,
   output logic                       write_latch_bit,
   output logic                       otp_mode,
   output logic                       quad_command_mode,
   output logic                       customer_lock,
   output logic [1:0]                 security_bits,
   output logic                       pin_write_guard,
   output logic                       active,
   output logic                       rejected
);
   typedef enum logic [1:0] {ST_IDLE, ST_CMD, ST_ADDR, ST_STANDBY}
      frame_type;

   // Two-flop synchronisers; only the second stage is read.
   logic [1:0] sclk_s_r, cs_s_r, wp_s_r;
   logic [3:0] sio_a_r, sio_b_r;
   logic       sclk_d_r, cs_d_r;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sclk_s_r <= 2'h0;
         cs_s_r   <= 2'h3;
         wp_s_r   <= 2'h3;
         sio_a_r  <= 4'h0;
         sio_b_r  <= 4'h0;
         sclk_d_r <= 1'b0;
         cs_d_r   <= 1'b1;
      end else begin
         sclk_s_r <= {sclk_s_r[0], sclk};
         cs_s_r   <= {cs_s_r[0], cs_n};
         wp_s_r   <= {wp_s_r[0], wp_n};
         sio_a_r  <= sio_in;
         sio_b_r  <= sio_a_r;
         sclk_d_r <= sclk_s_r[1];
         cs_d_r   <= cs_s_r[1];
      end
   end
   wire logic cs_low  = ~cs_s_r[1];
   wire logic sc_rise = sclk_s_r[1] & ~sclk_d_r;
   wire logic sc_fall = ~sclk_s_r[1] & sclk_d_r;
   wire logic cs_fall = ~cs_s_r[1] & cs_d_r;
   wire logic cs_rise = cs_s_r[1] & ~cs_d_r;

   // Framing state.
   frame_type   st_r, st_nxt;
   logic [7:0]  cmd_r;
   logic [31:0] shift_r;
   logic [5:0]  bits_r;
   logic [AW-1:0] addr_r;
   logic        known_r, rd_type_r, wr_type_r;
   logic        latch_r, otp_r, quad_r, cust_lock_r;
   logic [7:0]  out_r;
   logic        out_en_r;
   logic        rej_r;

   // One rising edge carries one bit, or four in quad command mode.
   wire logic [5:0] step = quad_r ? 6'h04 : 6'h01;
   wire logic [5:0] bits_nxt = 6'(bits_r + step);
   wire logic [31:0] shift_nxt = quad_r ? {shift_r[27:0], sio_b_r}
                                       : {shift_r[30:0], sio_b_r[0]};
   wire logic [7:0] cmd_in = shift_nxt[7:0];
   wire logic cmd_done = sc_rise && (st_r == ST_CMD) && (bits_nxt == 6'h08);
   wire logic addr_done = sc_rise && (st_r == ST_ADDR)
                          && (bits_nxt == 6'h20);
   wire logic on_byte = (bits_r[2:0] == 3'h0);

   // Command classification.
   function automatic logic needs_addr(input logic [7:0] c);
      return c == CMD_READ || c == CMD_FREAD || c == CMD_PP ||
             c == CMD_SE || c == CMD_BE32 || c == CMD_BE;
   endfunction
   function automatic logic is_read(input logic [7:0] c);
      return c == CMD_READ || c == CMD_FREAD || c == CMD_RDSR ||
             c == CMD_RDID;
   endfunction
   function automatic logic is_write(input logic [7:0] c);
      return c == CMD_LATCH_SET || c == CMD_WRDI || c == CMD_PP ||
             c == CMD_SE || c == CMD_BE32 || c == CMD_BE ||
             c == CMD_CE1 || c == CMD_CE2 || c == CMD_STATUS_WRITE ||
             c == CMD_OTP_ENTER || c == CMD_OTP_EXIT ||
             c == CMD_SEC_WRITE || c == CMD_QUAD_ENTER ||
             c == CMD_QUAD_LEAVE || c == CMD_NOP;
   endfunction
   // Quad enter is single-line only; quad exit is quad-only.
   wire logic cmd_known = is_read(cmd_in) ||
      (is_write(cmd_in) && !(cmd_in == CMD_QUAD_ENTER && quad_r) &&
       !(cmd_in == CMD_QUAD_LEAVE && !quad_r));

   // Protection checks on the captured target.
   wire logic lock_hit;
   flash_lock_map #(.AW(AW)) u_lock (
      .clk        (clk),
      .rst        (rst),
      .lock_we    (1'b0),
      .lock_val   (1'b0),
      .lock_all   (1'b0),
      .lock_addr  ('0),
      .chk_addr   (addr_r),
      .chk_locked (lock_hit)
   );
   wire logic [5:0] tgt_blk = addr_r[AW-1:BLK_LSB];
   wire logic area_guard = block_guarded(protect_code, protect_bottom,
                                         tgt_blk);
   wire logic otp_row_hi = addr_r[OTP_ROW_SEL];
   wire logic otp_row_locked = otp_row_hi ? factory_lock : cust_lock_r;
   wire logic chip_ok = (protect_code == CODE_NONE);
   wire logic is_prog = (cmd_r == CMD_PP);
   wire logic is_erase = (cmd_r == CMD_SE) || (cmd_r == CMD_BE32) ||
                         (cmd_r == CMD_BE);
   wire logic is_chip = (cmd_r == CMD_CE1) || (cmd_r == CMD_CE2);
   // In OTP mode the main array guard gives way to the row lock.
   wire logic target_ok = otp_r ?
                          (!otp_row_locked && is_prog) :
                          (!area_guard && !lock_hit);
   // A frame cut inside its address is refused, even on a byte boundary,
   // so that a stale captured address can never reach the engine.
   wire logic exec_ok = cs_rise && known_r && wr_type_r && on_byte &&
                        (st_r != ST_ADDR) && !engine_busy;
   wire logic mod_ok = exec_ok && latch_r;
   wire logic fire = mod_ok && ((is_prog || is_erase) ? target_ok :
                     is_chip ? (chip_ok && !otp_r) : 1'b0);

   // Frame sequencing.
   always_comb begin
      st_nxt = st_r;
      unique case (st_r)
         ST_IDLE:    if (cs_fall) st_nxt = ST_CMD;
         ST_CMD:     if (cmd_done) begin
                        st_nxt = !cmd_known ? ST_STANDBY :
                                 needs_addr(cmd_in) ? ST_ADDR : ST_CMD;
                     end
         ST_ADDR:    if (addr_done) st_nxt = ST_CMD;
         ST_STANDBY: st_nxt = ST_STANDBY;
      endcase
      if (!cs_low && st_r != ST_IDLE) begin
         st_nxt = ST_IDLE;
      end
      if (cs_fall) begin
         st_nxt = ST_CMD;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st_r <= ST_IDLE;
         bits_r <= 6'h00;
         shift_r <= 32'h0;
      end else begin
         st_r <= st_nxt;
         if (cs_fall) begin
            bits_r <= 6'h00;
         end else if (sc_rise && st_r != ST_STANDBY && cs_low) begin
            bits_r  <= bits_nxt;
            shift_r <= shift_nxt;
         end
      end
   end

   // Command and address capture.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cmd_r <= 8'h00;
         addr_r <= '0;
         known_r <= 1'b0;
         rd_type_r <= 1'b0;
         wr_type_r <= 1'b0;
      end else if (cs_fall) begin
         known_r <= 1'b0;
      end else if (cmd_done && !known_r) begin
         cmd_r <= cmd_in;
         known_r <= cmd_known;
         rd_type_r <= is_read(cmd_in);
         wr_type_r <= is_write(cmd_in);
      end else if (addr_done) begin
         addr_r <= shift_nxt[AW-1:0];
         wr_type_r <= !is_read(cmd_r);
      end
   end

   // Mode and latch flags; the latch drops after each modifying command.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         latch_r <= 1'b0;
         otp_r <= 1'b0;
         quad_r <= 1'b0;
         cust_lock_r <= 1'b0;
      end else if (exec_ok) begin
         unique case (cmd_r)
            CMD_LATCH_SET:  latch_r <= 1'b1;
            CMD_WRDI:       latch_r <= 1'b0;
            CMD_OTP_ENTER:  otp_r <= 1'b1;
            CMD_OTP_EXIT:   otp_r <= 1'b0;
            CMD_QUAD_ENTER: quad_r <= 1'b1;
            CMD_QUAD_LEAVE: quad_r <= 1'b0;
            CMD_SEC_WRITE:  if (latch_r) begin
                               cust_lock_r <= 1'b1;
                               latch_r <= 1'b0;
                            end
            default:        if (latch_r && cmd_r != CMD_NOP) latch_r <= 1'b0;
         endcase
      end
   end

   // Output shifting on falling edges; only the status read (CMD_RDSR) drives data.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         out_r <= 8'h00;
         out_en_r <= 1'b0;
      end else if (!cs_low || st_r == ST_STANDBY) begin
         out_en_r <= 1'b0;
      end else if (known_r && rd_type_r && cmd_r == CMD_RDSR &&
                   sc_fall && bits_r == 6'h08) begin
         out_r <= status_byte;
         out_en_r <= 1'b1;
      end else if (out_en_r && sc_fall) begin
         out_r <= {out_r[6:0], out_r[7]};
      end
   end

   // Result strobe to the array engine.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         op_start <= 1'b0;
         op_kind <= OP_NONE;
         op_addr <= '0;
         op_otp <= 1'b0;
         rej_r <= 1'b0;
      end else begin
         op_start <= fire;
         rej_r <= cs_rise && known_r && wr_type_r && !exec_ok;
         if (fire) begin
            op_kind <= is_prog ? OP_PROG : is_erase ? OP_ERASE : OP_CHIP;
            op_addr <= otp_r ? AW'(addr_r[OTP_ADDR_W-1:0]) : addr_r;
            op_otp <= otp_r;
         end
      end
   end

   assign sio_out = {3'h0, out_r[7]};
   assign sio_oe = {3'h0, out_en_r};
   assign write_latch_bit = latch_r;
   assign otp_mode = otp_r;
   assign quad_command_mode = quad_r;
   assign customer_lock = cust_lock_r;
   assign security_bits = {cust_lock_r, factory_lock};
   // The pin guard stands aside in quad lines or quad command mode. The
   // pin is read through its synchroniser, so the guard lags it by two.
   assign pin_write_guard = ~wp_s_r[1] & ~quad_lines_enable &
                            ~quad_r;
   assign active = (st_r == ST_CMD) || (st_r == ST_ADDR);
   assign rejected = rej_r;

   a_chip_gate: assert property (@(posedge clk) disable iff (rst)
      op_start && op_kind == OP_CHIP |-> $past(protect_code) == CODE_NONE)
      else $error("chip erase with protect code set");
   a_guard_top: assert property (@(posedge clk) disable iff (rst)
      op_start && !op_otp && !$past(protect_bottom) &&
      $past(protect_code) == 4'h1 |-> op_addr[AW-1:BLK_LSB] != BLK_TOP)
      else $error("top block not guarded");
   a_guard_bot: assert property (@(posedge clk) disable iff (rst)
      op_start && !op_otp && $past(protect_bottom) &&
      $past(protect_code) == 4'h6 |-> op_addr[AW-1] == 1'b1)
      else $error("low half not guarded");
   a_guard_all: assert property (@(posedge clk) disable iff (rst)
      op_start && !op_otp |-> $past(protect_code) <= CODE_MAX_PART)
      else $error("fully guarded array modified");
   a_latch_need: assert property (@(posedge clk) disable iff (rst)
      op_start |-> $past(latch_r))
      else $error("modify without write latch");
   a_busy_ignore: assert property (@(posedge clk) disable iff (rst)
      op_start |-> !$past(engine_busy))
      else $error("start while busy");
   a_otp_row: assert property (@(posedge clk) disable iff (rst)
      op_start && op_otp && op_addr[OTP_ROW_SEL] |-> !$past(factory_lock))
      else $error("locked factory row changed");
   a_standby_off: assert property (@(posedge clk) disable iff (rst)
      st_r == ST_STANDBY |=> !out_en_r)
      else $error("output on in standby");
   a_pin_quad: assert property (@(posedge clk) disable iff (rst)
      quad_r |-> !pin_write_guard)
      else $error("pin guard active in quad mode");
endmodule

//--- sim/flash_host_model.sv
// Host model of the serial link: drives serial clock, select and data.
// Assumes the bench calls xfer from one process, clocked by clk.
`timescale 1ns/1ns
module flash_host_model (
   input  wire logic       clk,
   input  wire logic [3:0] sio_out,
   input  wire logic [3:0] sio_oe,
   input  wire logic       active,
   output logic            sclk,
   output logic            cs_n,
   output logic [3:0]      sio_in
);
   // Mode 0: the clock is parked low and stands still between frames.
   initial begin
      sclk = 1'b0;
      cs_n = 1'b1;
      sio_in = 4'hA;
   end

   // Waits n edges, then steps just past the edge.
   task automatic wait_clk(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   // One frame: nb bits out MSB first, nr more clocks reading line 0.
   task automatic xfer(input logic [31:0] d, input int nb, input int nr,
                       input logic q, output logic [7:0] rd,
                       output logic act, output logic oe);
      int w;
      w = q ? 4 : 1;
      oe = 1'b0;
      rd = 8'h00;
      wait_clk(1);
      cs_n = 1'b0;
      for (int i = 0; i < nb + nr; i += w) begin
         // Data changes while the clock is low and holds over the rise.
         if (i < nb) sio_in = q ? d[31-i -: 4] : {3'h0, d[31-i]};
         wait_clk(8);
         rd = {rd[6:0], sio_out[0]};
         oe = oe | sio_oe[0];
         sclk = 1'b1;
         wait_clk(8);
         sclk = 1'b0;
      end
      act = active;
      wait_clk(8);
      cs_n = 1'b1;
      // A released line must not keep showing the last bit.
      sio_in = ~sio_in;
      wait_clk(40);
   endtask
endmodule

//--- sim/serial_flash_protect_and_framing_test.sv
// Self-checking bench for the flash framing and protection core.
// Assumes the host model drives the link and clk runs at 100 MHz.
`timescale 1ns/1ns
module serial_flash_protect_and_framing_test;
   import flash_guard_pkg::*;
   logic              clk, rst, sclk, cs_n, wp_n, protect_bottom;
   logic              quad_lines_enable, factory_lock, engine_busy;
   logic              op_start, op_otp, write_latch_bit, otp_mode;
   logic              quad_command_mode, customer_lock, pin_write_guard;
   logic              active, rejected, act, oe, ok_exp;
   logic [3:0]        sio_in, sio_out, sio_oe, protect_code;
   logic [7:0]        status_byte, rd;
   logic [1:0]        security_bits;
   logic [ADDR_W-1:0] op_addr;
   op_type            op_kind;
   int                err_count, num_checks, ops, rejs, n, r, sp, m;

   flash_guard dut_u (.clk(clk), .rst(rst), .sclk(sclk), .cs_n(cs_n),
      .sio_in(sio_in), .sio_out(sio_out), .sio_oe(sio_oe), .wp_n(wp_n),
      .protect_code(protect_code), .protect_bottom(protect_bottom),
      .quad_lines_enable(quad_lines_enable), .factory_lock(factory_lock),
      .engine_busy(engine_busy), .status_byte(status_byte),
      .op_start(op_start), .op_kind(op_kind), .op_addr(op_addr),
      .op_otp(op_otp), .write_latch_bit(write_latch_bit),
      .otp_mode(otp_mode), .quad_command_mode(quad_command_mode),
      .customer_lock(customer_lock), .security_bits(security_bits),
      .pin_write_guard(pin_write_guard), .active(active),
      .rejected(rejected));

   flash_host_model host_u (.clk(clk), .sio_out(sio_out), .sio_oe(sio_oe),
      .active(active), .sclk(sclk), .cs_n(cs_n), .sio_in(sio_in));

   // Free-running system clock.
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // Counts one-cycle strobes so no pulse is missed between checks.
   always @(posedge clk) begin
      if (op_start === 1'b1) ops++;
      if (rejected === 1'b1) rejs++;
   end

   task automatic cmp(input string nm, input logic [31:0] e,
                      input logic [31:0] g);
      num_checks++;
      if (g !== e) begin
         $display("[ERR] %s expected %0h seen %0h", nm, e, g);
         err_count++;
      end
   endtask

   task automatic send(input logic [31:0] d, input int nb, input int nr);
      host_u.xfer(d, nb, nr, quad_command_mode, rd, act, oe);
   endtask

   // Latch set, then a program frame; ok says whether it must run.
   task automatic tryprog(input logic [21:0] a, input logic ok);
      int k;
      k = ops;
      send({CMD_LATCH_SET, 24'h0}, 8, 0);
      send({CMD_PP, 2'b00, a}, 32, 0);
      cmp("op count", k + ok, ops);
      cmp("latch drop", 0, write_latch_bit);
      if (ok) begin
         cmp("op kind", OP_PROG, op_kind);
         cmp("op addr", otp_mode ? 32'(a[9:0]) : 32'(a), op_addr);
      end
   endtask

   // Size of the protected run; written apart from the design's decoder.
   function automatic int span(input int c);
      return c == 0 ? 0 : (c > 6 ? 64 : 1 << (c - 1));
   endfunction

   task automatic results();
      $display("checks %0d mismatches %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   // Watchdog: the full sequence needs about 55k clock cycles.
   initial begin
      #1000000;
      err_count++;
      results();
   end

   // Main sequence.
   initial begin
      rst = 1'b1;
      {wp_n, protect_bottom, quad_lines_enable} = 3'b100;
      {factory_lock, engine_busy} = 2'b00;
      protect_code = 4'h0;
      status_byte = 8'hA5;
      repeat (5) @(posedge clk);
      #1;
      rst = 1'b0;
      host_u.wait_clk(3);
      cmp("idle outputs", 0, {sio_oe, write_latch_bit, otp_mode,
          quad_command_mode, customer_lock, active});
      send({8'hFF, 24'h0}, 8, 8);
      cmp("unknown active", 0, act);
      cmp("unknown drive", 0, oe);
      send({CMD_RDSR, 24'h0}, 8, 8);
      cmp("status data", 8'hA5, rd);
      cmp("read active", 1, act);
      send({CMD_RDSR, 24'h0}, 8, 3);
      cmp("early end", 3'b101, rd[2:0]);
      cmp("released", 0, sio_oe);
      send({CMD_LATCH_SET, 24'h0}, 7, 0);
      cmp("short latch", 0, write_latch_bit);
      n = ops;
      send({CMD_PP, 24'h010000}, 32, 0);
      cmp("no latch", n, ops);
      r = rejs;
      send({CMD_LATCH_SET, 24'h0}, 8, 0);
      cmp("latch set", 1, write_latch_bit);
      send({CMD_PP, 24'h010000}, 31, 0);
      cmp("odd length", n, ops);
      cmp("odd reject", r + 1, rejs);
      send({CMD_LATCH_SET, 24'h0}, 8, 0);
      engine_busy = 1'b1;
      send({CMD_PP, 24'h010000}, 32, 0);
      cmp("busy drop", n, ops);
      cmp("busy reject", r + 2, rejs);
      engine_busy = 1'b0;
      // Probe each code at the edge of its run, inside and just outside.
      // The block index is masked into 0..63 and compared as a full int: a sized cast of
      // a signed int would stay signed and misjudge block 63.
      for (int b = 0; b < 2; b++) begin
         for (int c = 0; c < 16; c++) begin
            protect_bottom = b[0];
            protect_code = c[3:0];
            sp = span(c);
            for (int p = 0; p < 2; p++) begin
               n = b ? sp - 1 + p : 64 - sp - p;
               m = n & 63;
               ok_exp = !(b ? m < sp : m >= 64 - sp);
               tryprog({6'(m), 16'h0ABC}, ok_exp);
            end
         end
      end
      // Chip erase through both opcodes, free and under protection.
      for (int i = 0; i < 4; i++) begin
         protect_code = i[1] ? (i[0] ? 4'h8 : 4'h1) : 4'h0;
         n = ops;
         send({CMD_LATCH_SET, 24'h0}, 8, 0);
         send({i[0] ? CMD_CE2 : CMD_CE1, 24'h0}, 8, 0);
         cmp("erase count", n + !i[1], ops);
         if (!i[1]) cmp("erase kind", OP_CHIP, op_kind);
      end
      wp_n = 1'b0;
      host_u.wait_clk(2);
      cmp("pin guard", 1, pin_write_guard);
      send({CMD_QUAD_ENTER, 24'h0}, 8, 0);
      cmp("quad on", 1, quad_command_mode);
      cmp("quad guard", 0, pin_write_guard);
      send({CMD_QUAD_LEAVE, 24'h0}, 8, 0);
      cmp("quad off", 0, quad_command_mode);
      quad_lines_enable = 1'b1;
      host_u.wait_clk(2);
      cmp("lines guard", 0, pin_write_guard);
      send({CMD_OTP_ENTER, 24'h0}, 8, 0);
      cmp("otp on", 1, otp_mode);
      tryprog(22'h000250, 1'b1);
      cmp("otp target", 1, op_otp);
      factory_lock = 1'b1;
      host_u.wait_clk(2);
      cmp("factory bit", 2'b01, security_bits);
      tryprog(22'h000250, 1'b0);
      send({CMD_LATCH_SET, 24'h0}, 8, 0);
      send({CMD_SEC_WRITE, 24'h0}, 8, 0);
      cmp("customer bit", 2'b11, security_bits);
      cmp("customer lock", 1, customer_lock);
      tryprog(22'h000100, 1'b0);
      send({CMD_OTP_EXIT, 24'h0}, 8, 0);
      cmp("otp off", 0, otp_mode);
      results();
   end
endmodule
